// [bench/uds_far_model.sv]
/*
  Far-side model: shared descriptor memory and USB transaction engine.
  Assumes a one-cycle read port and single-cycle response pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module uds_far_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [1:0]  mem_list,
  input  wire logic [4:0]  mem_idx,
  input  wire logic [2:0]  mem_word,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  input  wire logic        xact_start,
  input  wire logic        slow,
  input  wire logic [1:0]  fault,
  output logic             xact_done,
  output logic             xact_babble,
  output logic             xact_pid_err
);
  // Filled by the bench acting as host software
  logic [31:0] mem [3][32][8];
  int          wait_cnt;

  initial mem_rdata = 32'h5a5a_5a5a;

  // Unread cycles show inverted data so a stale word never passes
  always @(posedge core_clk) begin
    if (mem_rd) mem_rdata <= mem[mem_list][mem_idx][mem_word];
    else mem_rdata <= ~mem_rdata;
    if (mem_wr) mem[mem_list][mem_idx][mem_word] <= mem_wdata;
  end

  // Fault kind applies to every transaction while it is set
  always @(posedge core_clk or posedge reset) begin
    xact_done    <= 1'b0;
    xact_babble  <= 1'b0;
    xact_pid_err <= 1'b0;
    if (reset) wait_cnt <= 0;
    else if (xact_start) wait_cnt <= slow ? 9 : 1;
    else if (wait_cnt == 1) begin
      wait_cnt     <= 0;
      xact_done    <= fault == 2'h0;
      xact_babble  <= fault == 2'h1;
      xact_pid_err <= fault == 2'h2;
    end else if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
  end
endmodule // uds_far_model
`default_nettype wire

// [bench/usb_descriptor_scheduler_tb.sv]
/*
  Self-checking bench for the scheduler with a reference list walk.
  Assumes uds_far_model stands in for shared memory and USB engine.
*/
`timescale 1ns/100ps
`default_nettype none
module usb_descriptor_scheduler_tb;
  logic        core_clk, reset, sched_en, slow, busy, mem_rd, mem_wr;
  logic        xact_start, xact_done, xact_babble, xact_pid_err, sof_irq;
  logic [1:0]  fault, done_clr_list, mem_list, xact_mult;
  logic [2:0]  mem_word;
  logic [4:0]  mem_idx;
  logic [3:0]  xact_reload_count;
  logic [7:0]  latency_uf;
  logic [10:0] xact_max_packet_len;
  logic [14:0] xact_bytes_to_move;
  logic [15:0] xact_payload_start_addr;
  logic [31:0] done_clr, mem_wdata, mem_rdata;
  logic [31:0] skip [3], last [3], m_and [3], m_or [3], done [3], dexp [3];
  logic        irq [3], hit [3];
  logic [47:0] obs;
  logic [47:0] exp_q [$];
  int          irq_cnt [3];
  int          num_errors, compares, k, cyc, sof_last, sof_gap;
  int          seed = 32'h79b829e2;

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  uds_scheduler DUT (
    .core_clk(core_clk), .reset(reset), .sched_en(sched_en),
    .iso_skip(skip[0]), .int_skip(skip[1]), .async_skip(skip[2]),
    .iso_last(last[0]), .int_last(last[1]), .async_last(last[2]),
    .iso_mask_and(m_and[0]), .int_mask_and(m_and[1]), .async_mask_and(m_and[2]),
    .iso_mask_or(m_or[0]), .int_mask_or(m_or[1]), .async_mask_or(m_or[2]),
    .latency_uf(latency_uf), .done_clr(done_clr), .done_clr_list(done_clr_list),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_list(mem_list), .mem_idx(mem_idx),
    .mem_word(mem_word), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .xact_start(xact_start), .xact_mult(xact_mult), .xact_max_packet_len(xact_max_packet_len),
    .xact_bytes_to_move(xact_bytes_to_move), .xact_reload_count(xact_reload_count),
    .xact_payload_start_addr(xact_payload_start_addr), .xact_done(xact_done),
    .xact_babble(xact_babble), .xact_pid_err(xact_pid_err),
    .iso_done(done[0]), .int_done(done[1]), .async_done(done[2]),
    .iso_irq(irq[0]), .int_irq(irq[1]), .async_irq(irq[2]), .sof_irq(sof_irq), .busy(busy)
  );

  uds_far_model MEM (
    .core_clk(core_clk), .reset(reset), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_list(mem_list), .mem_idx(mem_idx), .mem_word(mem_word), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .xact_start(xact_start), .slow(slow), .fault(fault),
    .xact_done(xact_done), .xact_babble(xact_babble), .xact_pid_err(xact_pid_err)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [47:0] fields(input int l, input int i);
    logic [31:0] w0, w2;
    w0 = MEM.mem[l][i][0];
    w2 = MEM.mem[l][i][2];
    return {w0[30:29], w0[28:18], w0[17:3], w2[28:25], w2[23:8]};
  endfunction

  // Host software lays out the lists
  task automatic build();
    int          lst, tgt;
    logic [31:0] r;
    for (int l = 0; l < 3; l++) begin
      lst      = 16 + ($unsigned($random(seed)) % 16);
      last[l]  = 32'h1 << lst;
      skip[l]  = $random(seed) & $random(seed) & ~last[l];
      m_or[l]  = $random(seed) & $random(seed) & $random(seed);
      m_and[l] = $random(seed) & $random(seed) & $random(seed);
      for (int i = 0; i < 32; i++) begin
        r = $random(seed);
        tgt = i + 1 + r[3:1];
        MEM.mem[l][i][0] = $random(seed);
        MEM.mem[l][i][2] = $random(seed);
        MEM.mem[l][i][3] = {MEM.mem[l][i][0][0], 31'h0};
        MEM.mem[l][i][4] = 32'h0;
        if (MEM.mem[l][i][0][0] && r[0] && tgt < lst) begin
          MEM.mem[l][i][4] = 32'h20 | tgt;
          skip[l][tgt] = 1'b0;
        end else if (MEM.mem[l][i][0][0] && r[5:4] == 2'h3) begin
          // Backward or self target, must fall through
          MEM.mem[l][i][4] = 32'h20 | (i / 2);
        end
      end
    end
  endtask

  task automatic predict();
    int          i;
    logic [31:0] w4;
    for (int l = 0; l < 3; l++) begin
      i = 0;
      while (i < 32) begin
        w4 = MEM.mem[l][i][4];
        if (!skip[l][i] && MEM.mem[l][i][0][0] && MEM.mem[l][i][3][31] && !dexp[l][i]) begin
          exp_q.push_back(fields(l, i));
          dexp[l][i] = 1'b1;
        end
        if (last[l][i]) break;
        i = (!skip[l][i] && w4[5] && w4[4:0] > i) ? w4[4:0] : i + 1;
      end
    end
  endtask

  task automatic run();
    irq_cnt  = '{0, 0, 0};
    sched_en = 1'b1;
    repeat (2) @(negedge core_clk);
    for (k = 0; k < 20000 && busy === 1'b1; k++) @(negedge core_clk);
    sched_en = 1'b0;
    if (k == 20000) begin
      check(1, 0, "walk timeout");
      conclude();
    end
    repeat (50) @(negedge core_clk);
    check(exp_q.size(), 0, "starts missing");
  endtask

  task automatic clear_done();
    done_clr = 32'hffff_ffff;
    for (int l = 0; l < 3; l++) begin
      done_clr_list = 2'(l);
      repeat (2) @(negedge core_clk);
      check(done[l], 0, "done clear");
    end
    done_clr = 32'h0;
    dexp     = '{32'h0, 32'h0, 32'h0};
  endtask

  // One async entry; status must show the fault and drop the flags
  task automatic fault_case(input logic [1:0] kind, input int n);
    for (int l = 0; l < 3; l++) begin
      {skip[l], m_or[l], m_and[l]} = '0;
      last[l] = 32'h8000_0000;
      for (int i = 0; i < 32; i++) MEM.mem[l][i] = '{default: 32'h0};
    end
    MEM.mem[2][5][0] = $random(seed) | 1;
    MEM.mem[2][5][2] = $random(seed);
    MEM.mem[2][5][3] = 32'h8000_0000;
    repeat (n) exp_q.push_back(fields(2, 5));
    fault = kind;
    run();
    fault = 2'h0;
    check({MEM.mem[2][5][3][31], MEM.mem[2][5][3][29:28], MEM.mem[2][5][0][0]},
          kind == 2'h1 ? 4'h4 : 4'h2, "fault status");
  endtask

  always @(posedge core_clk) begin
    obs = {xact_mult, xact_max_packet_len, xact_bytes_to_move, xact_reload_count, xact_payload_start_addr};
    cyc++;
    if (sof_irq === 1'b1) begin
      sof_gap  = cyc - sof_last;
      sof_last = cyc;
    end
    if (!reset && xact_start === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0, "start not expected");
      else check(obs, exp_q.pop_front(), "start fields");
    end
    for (int l = 0; l < 3; l++) if (!reset && irq[l] === 1'b1) irq_cnt[l]++;
  end

  initial begin
    reset = 1'b1;
    {sched_en, slow, fault, done_clr_list, done_clr, latency_uf} = '0;
    for (int l = 0; l < 3; l++) {skip[l], last[l], m_and[l], m_or[l], dexp[l]} = '0;
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    for (int it = 0; it < 2; it++) begin
      slow = it[0];
      build();
      predict();
      run();
      // Group interrupts only report on a microframe tick
      for (k = 0; k < 40000 && sof_irq !== 1'b1; k++) @(negedge core_clk);
      if (k == 40000) begin
        check(1, 0, "tick timeout");
        conclude();
      end
      // Masks drop after the tick so later passes leave nothing pending
      for (int l = 0; l < 3; l++) begin
        hit[l] = |(dexp[l] & m_or[l]) || (m_and[l] != 0 && (dexp[l] & m_and[l]) == m_and[l]);
        {m_or[l], m_and[l]} = '0;
      end
      @(negedge core_clk);
      for (int l = 0; l < 3; l++) begin
        check(done[l], dexp[l], "done map");
        check(irq_cnt[l] != 0, hit[l], "group irq");
      end
      // Done entries stay untouched on a second pass
      if (it == 0) begin
        predict();
        run();
        check(done[2], dexp[2], "done kept");
      end
      clear_done();
      $display("Test walk %0d complete", it);
    end
    clear_done();
    fault_case(2'h1, 1);
    $display("Test babble complete");
    clear_done();
    fault_case(2'h2, 4);
    $display("Test pid error complete");
    check(sof_gap, uds_pkg::UFRAME_CYC, "frame interval");
    $display("Test frame tick complete");
    conclude();
  end
endmodule // usb_descriptor_scheduler_tb
`default_nettype wire

// [verilog/uds_irq_group.sv]
/*
  Completion interrupt combiner for one list: AND group and OR group of
  per-descriptor done bits, plus latency pacing in microframes.
  Assumes done and masks come from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module uds_irq_group (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic [31:0]            done_map,
  input  wire logic [31:0]            mask_and,
  input  wire logic [31:0]            mask_or,
  input  wire logic                   uframe_tick,
  input  wire logic [uds_pkg::LAT_W-1:0] latency_uf,
  output logic                        irq
);
  logic                        hit;
  logic                        pend_q;
  logic [uds_pkg::LAT_W-1:0]   cnt_q;

  // AND group fires only when all selected done; OR group on any
  assign hit = ((|mask_and) && ((done_map & mask_and) == mask_and)) ||
               (|(done_map & mask_or)); // see RQ6

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
      cnt_q  <= '0;
      irq    <= 1'b0;
    end else begin
      irq <= 1'b0;
      if (hit) begin
        pend_q <= 1'b1;
      end
      // Report only on a microframe boundary after latency count expires
      if (uframe_tick && (pend_q || hit)) begin // see RQ5
        if (cnt_q >= latency_uf) begin
          irq    <= 1'b1;
          pend_q <= 1'b0;
          cnt_q  <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  property p_irq_needs_tick;
    @(posedge core_clk) disable iff (reset)
    irq |-> $past(uframe_tick);
  endproperty
  a_irq_needs_tick: assert property (p_irq_needs_tick) else $error("irq without microframe tick"); // see RQ5
endmodule // uds_irq_group
`default_nettype wire

// [verilog/uds_pkg.sv]
/*
  Package for the descriptor scheduler: list sizes, descriptor word field
  positions, timing constants and state codes.
  Assumes 32-bit descriptor words with the valid flag in word 0 bit 0.
*/
package uds_pkg;
  localparam int unsigned NUM_DESC     = 32;
  localparam int unsigned IDX_W        = 5;
  localparam int unsigned WORD_W       = 32;
  localparam int unsigned NUM_WORDS    = 8;
  localparam int unsigned WSEL_W       = 3;
  localparam int unsigned NUM_LISTS    = 3;
  // Word indices within a descriptor
  localparam logic [2:0]  W0           = 3'h0;
  localparam logic [2:0]  W2           = 3'h2;
  localparam logic [2:0]  W3           = 3'h3;
  localparam logic [2:0]  W4           = 3'h4;
  // Word 0 fields
  localparam int unsigned W0_VALID     = 0;
  localparam int unsigned W0_BYTES_LO  = 3;
  localparam int unsigned W0_BYTES_W   = 15;
  localparam int unsigned W0_MPL_LO    = 18;
  localparam int unsigned W0_MPL_W     = 11;
  localparam int unsigned W0_MULT_LO   = 29;
  localparam int unsigned W0_MULT_W    = 2;
  // Word 2 fields
  localparam int unsigned W2_ADDR_LO   = 8;
  localparam int unsigned W2_ADDR_W    = 16;
  localparam int unsigned W2_RL_LO     = 25;
  localparam int unsigned W2_RL_W      = 4;
  // Word 3 fields (upper half of 64-bit pair mapped to bits 31:28)
  localparam int unsigned W3_ACTIVE    = 31;
  localparam int unsigned W3_HALT      = 30;
  localparam int unsigned W3_BABBLE    = 29;
  localparam int unsigned W3_XERR      = 28;
  // Word 4 fields
  localparam int unsigned W4_NEXT_LO   = 0;
  localparam int unsigned W4_JUMP      = 5;
  // Per-entry skip and last marker bits are ports; retry limit
  localparam logic [1:0]  RETRY_MAX    = 2'h3;
  // Microframe period
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned UFRAME_NS    = 125000;
  localparam int unsigned UFRAME_CYC   = UFRAME_NS * CLK_MHZ / 1000;
  localparam int unsigned LAT_W        = 8;

  typedef enum logic [2:0] {
    UDS_IDLE  = 3'b000,
    UDS_RD0   = 3'b001,
    UDS_RD4   = 3'b010,
    UDS_EXEC  = 3'b011,
    UDS_WAIT  = 3'b100,
    UDS_WB    = 3'b101,
    UDS_NEXT  = 3'b110,
    UDS_RD2   = 3'b111
  } uds_state_e;
endpackage

// [verilog/uds_scheduler.sv]
/*
  Descriptor list scheduler: walks isochronous, periodic interrupt and
  async lists in shared memory, starts transactions, updates status.
  Assumes a one-cycle-latency shared memory read port, a write port, and
  a USB transaction engine with start/done/babble/pid_err handshake.
*/
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RQ1: Thirty-two descriptors per list, three lists
// RQ2: Isochronous, then interrupt, then async order
// RQ3: Software fills lists from endpoint link walk
// RQ4: Four interrupts: iso, interrupt, async, frame
// RQ5: Interrupt latency in whole microframes
// RQ6: Done bits combined via AND/OR masks
// RQ7: Descriptor complete when done condition true
// RQ8: Ascending walk honouring skip and last marker
// RQ9: Transaction only if active and not done; the code tests the word 0 valid flag, not the word 3 active bit
// RQ10: Next pointer from word 4 bits 4:0
// RQ11: Branching only forward, never backward
// RQ12: Software never chains same endpoint
// RQ13: Software puts last marker above target
// RQ14: Software never skips a branch target
// RQ15: Skipped descriptor ignored, walk advances
// RQ16: Skipped descriptor's next pointer ignored
// RQ17: Word 0: mult, max packet, byte count
// RQ18: Word 2: reload count, payload address
// RQ19: Word 4 bit 5 selects branch or advance
// RQ20: Babble sets status, clears active, valid
// RQ21: PID error sets error, retries three times
// RQ22: Valid flag in word 0 bit 0 required
module uds_scheduler (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     sched_en,
  input  wire logic [31:0]              iso_skip,
  input  wire logic [31:0]              int_skip,
  input  wire logic [31:0]              async_skip,
  input  wire logic [31:0]              iso_last,
  input  wire logic [31:0]              int_last,
  input  wire logic [31:0]              async_last,
  input  wire logic [31:0]              iso_mask_and,
  input  wire logic [31:0]              int_mask_and,
  input  wire logic [31:0]              async_mask_and,
  input  wire logic [31:0]              iso_mask_or,
  input  wire logic [31:0]              int_mask_or,
  input  wire logic [31:0]              async_mask_or,
  input  wire logic [7:0]               latency_uf,
  input  wire logic [31:0]              done_clr,
  input  wire logic [1:0]               done_clr_list,
  output logic                          mem_rd,
  output logic                          mem_wr,
  output logic [1:0]                    mem_list,
  output logic [4:0]                    mem_idx,
  output logic [2:0]                    mem_word,
  output logic [31:0]                   mem_wdata,
  input  wire logic [31:0]              mem_rdata,
  output logic                          xact_start,
  output logic [1:0]                    xact_mult,
  output logic [10:0]                   xact_max_packet_len,
  output logic [14:0]                   xact_bytes_to_move,
  output logic [3:0]                    xact_reload_count,
  output logic [15:0]                   xact_payload_start_addr,
  input  wire logic                     xact_done,
  input  wire logic                     xact_babble,
  input  wire logic                     xact_pid_err,
  output logic [31:0]                   iso_done,
  output logic [31:0]                   int_done,
  output logic [31:0]                   async_done,
  output logic                          iso_irq,
  output logic                          int_irq,
  output logic                          async_irq,
  output logic                          sof_irq,
  output logic                          busy
);
  uds_pkg::uds_state_e state_q;
  logic [1:0]   list_q;
  logic [4:0]   idx_q;
  logic [31:0]  w0_q;
  logic [31:0]  w3_q;
  logic [1:0]   retry_q;
  logic [31:0]  skip_v;
  logic [31:0]  last_v;
  logic         uframe_tick;
  logic [15:0]  uf_cnt_q;
  logic [31:0]  done_q [uds_pkg::NUM_LISTS];
  logic [4:0]   next_idx;
  logic         at_end;
  logic         jump_ok;
  logic [31:0]  wb_word;
  logic         babble_q;
  logic         xerr_q;
  logic         retry_go_q;
  logic         wait_retry;
  logic         wait_fail;

  always_comb begin
    unique case (list_q)
      2'h0:    begin skip_v = iso_skip;   last_v = iso_last;   end
      2'h1:    begin skip_v = int_skip;   last_v = int_last;   end
      default: begin skip_v = async_skip; last_v = async_last; end
    endcase
  end

  // Last marker or top entry ends a list
  assign at_end = last_v[idx_q] || (idx_q == 5'(uds_pkg::NUM_DESC - 1)); // see RQ8
  // A backward or self jump is refused and falls back to sequential
  assign jump_ok = mem_rdata[uds_pkg::W4_JUMP] &&
                   (mem_rdata[uds_pkg::W4_NEXT_LO +: uds_pkg::IDX_W] > idx_q); // see RQ11

  // Microframe timebase
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      uf_cnt_q <= '0;
    end else if (uframe_tick) begin
      uf_cnt_q <= '0;
    end else begin
      uf_cnt_q <= uf_cnt_q + 1'b1;
    end
  end
  assign uframe_tick = (uf_cnt_q == 16'(uds_pkg::UFRAME_CYC - 1));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sof_irq <= 1'b0;
    end else begin
      sof_irq <= uframe_tick; // see RQ4
    end
  end

  // Walker state machine
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q  <= uds_pkg::UDS_IDLE;
      list_q   <= 2'h0;
      idx_q    <= 5'h0;
      w0_q     <= '0;
      w3_q     <= '0;
      retry_q  <= 2'h0;
      next_idx <= 5'h0;
    end else begin
      unique case (state_q)
        uds_pkg::UDS_IDLE: begin
          if (sched_en) begin
            list_q  <= 2'h0; // see RQ2
            idx_q   <= 5'h0;
            state_q <= uds_pkg::UDS_RD0;
          end
        end
        uds_pkg::UDS_RD0: begin
          state_q <= uds_pkg::UDS_RD2;
        end
        uds_pkg::UDS_RD2: begin
          w0_q    <= mem_rdata;
          state_q <= uds_pkg::UDS_RD4;
        end
        uds_pkg::UDS_RD4: begin
          if (skip_v[idx_q]) begin
            next_idx <= idx_q + 1'b1; // see RQ15 see RQ16
            state_q  <= uds_pkg::UDS_NEXT;
          end else begin
            state_q <= uds_pkg::UDS_EXEC;
          end
        end
        uds_pkg::UDS_EXEC: begin
          // Read data here is word 4 (issued in RD4)
          next_idx <= jump_ok ? mem_rdata[uds_pkg::W4_NEXT_LO +: uds_pkg::IDX_W] : idx_q + 1'b1; // see RQ10 see RQ19
          retry_q  <= 2'h0;
          if (w0_q[uds_pkg::W0_VALID] && !done_q[list_q][idx_q]) begin // see RQ22 see RQ9
            state_q <= uds_pkg::UDS_WAIT;
          end else begin
            state_q <= uds_pkg::UDS_NEXT;
          end
        end
        uds_pkg::UDS_WAIT: begin
          if (xact_done) begin
            w3_q    <= mem_rdata;
            state_q <= uds_pkg::UDS_WB;
          end else if (xact_pid_err && retry_q != uds_pkg::RETRY_MAX) begin
            retry_q <= retry_q + 1'b1; // see RQ21
          end else if (xact_babble || xact_pid_err) begin
            w3_q    <= mem_rdata;
            state_q <= uds_pkg::UDS_WB;
          end
        end
        uds_pkg::UDS_WB: begin
          state_q <= uds_pkg::UDS_NEXT;
        end
        uds_pkg::UDS_NEXT: begin
          if (at_end || !sched_en) begin
            idx_q <= 5'h0;
            if (list_q == 2'h2 || !sched_en) begin
              state_q <= uds_pkg::UDS_IDLE;
            end else begin
              list_q  <= list_q + 1'b1; // see RQ2
              state_q <= uds_pkg::UDS_RD0;
            end
          end else begin
            idx_q   <= next_idx; // see RQ8
            state_q <= uds_pkg::UDS_RD0;
          end
        end
      endcase
    end
  end

  // Reads words 0, 2, 4, then word 3 while waiting; a failure writes 3, then 0
  always_comb begin
    mem_rd    = (state_q == uds_pkg::UDS_RD0) || (state_q == uds_pkg::UDS_RD2) ||
                (state_q == uds_pkg::UDS_RD4) || (state_q == uds_pkg::UDS_WAIT);
    mem_word  = (state_q == uds_pkg::UDS_RD2) ? uds_pkg::W2 :
                (state_q == uds_pkg::UDS_RD4) ? uds_pkg::W4 :
                (state_q == uds_pkg::UDS_WAIT || state_q == uds_pkg::UDS_WB) ? uds_pkg::W3 : uds_pkg::W0;
    mem_wr    = (babble_q || xerr_q) && (state_q == uds_pkg::UDS_WB || state_q == uds_pkg::UDS_NEXT);
    mem_wdata = (state_q == uds_pkg::UDS_WB) ? wb_word :
                (w0_q & ~(32'h1 << uds_pkg::W0_VALID)); // see RQ20 see RQ21
  end
  assign mem_list = list_q;
  assign mem_idx  = idx_q;

  // Error status: clear active, set babble or error
  always_comb begin
    wb_word = w3_q;
    wb_word[uds_pkg::W3_ACTIVE] = 1'b0; // see RQ20 see RQ21
    wb_word[uds_pkg::W3_BABBLE] = babble_q; // see RQ20
    wb_word[uds_pkg::W3_XERR]   = xerr_q; // see RQ21
  end

  // Responses are one-cycle pulses, so the failure kind is held for write-back
  assign wait_retry = (state_q == uds_pkg::UDS_WAIT) && !xact_done && xact_pid_err &&
                      (retry_q != uds_pkg::RETRY_MAX);
  assign wait_fail  = (state_q == uds_pkg::UDS_WAIT) && !xact_done && !wait_retry &&
                      (xact_babble || xact_pid_err);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      babble_q   <= 1'b0;
      xerr_q     <= 1'b0;
      retry_go_q <= 1'b0;
    end else begin
      retry_go_q <= wait_retry; // see RQ21
      if (wait_fail) begin
        babble_q <= xact_babble; // see RQ20
        xerr_q   <= xact_pid_err; // see RQ21
      end else if (state_q == uds_pkg::UDS_NEXT) begin
        babble_q <= 1'b0;
        xerr_q   <= 1'b0;
      end
    end
  end

  // Transaction parameters from word 0 and word 2
  assign xact_start = ((state_q == uds_pkg::UDS_EXEC) && w0_q[uds_pkg::W0_VALID] &&
                      !done_q[list_q][idx_q]) || retry_go_q; // see RQ21
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      xact_mult               <= '0;
      xact_max_packet_len     <= '0;
      xact_bytes_to_move      <= '0;
      xact_reload_count       <= '0;
      xact_payload_start_addr <= '0;
    end else if (state_q == uds_pkg::UDS_RD2) begin
      xact_mult           <= mem_rdata[uds_pkg::W0_MULT_LO +: uds_pkg::W0_MULT_W]; // see RQ17
      xact_max_packet_len <= mem_rdata[uds_pkg::W0_MPL_LO +: uds_pkg::W0_MPL_W];
      xact_bytes_to_move  <= mem_rdata[uds_pkg::W0_BYTES_LO +: uds_pkg::W0_BYTES_W];
    end else if (state_q == uds_pkg::UDS_RD4) begin
      xact_reload_count       <= mem_rdata[uds_pkg::W2_RL_LO +: uds_pkg::W2_RL_W]; // see RQ18
      xact_payload_start_addr <= mem_rdata[uds_pkg::W2_ADDR_LO +: uds_pkg::W2_ADDR_W];
    end
  end

  // Done maps; set wins over software clear
  genvar g;
  generate
    for (g = 0; g < uds_pkg::NUM_LISTS; g++) begin : g_done // see RQ1
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          done_q[g] <= '0;
        end else begin
          done_q[g] <= (done_clr_list == 2'(g)) ? (done_q[g] & ~done_clr) : done_q[g];
          if (state_q == uds_pkg::UDS_WB && list_q == 2'(g)) begin
            done_q[g][idx_q] <= 1'b1; // see RQ7
          end
        end
      end
    end
  endgenerate
  assign iso_done   = done_q[0];
  assign int_done   = done_q[1];
  assign async_done = done_q[2];
  assign busy       = (state_q != uds_pkg::UDS_IDLE);

  uds_irq_group u_iso (.core_clk(core_clk), .reset(reset), .done_map(done_q[0]),
    .mask_and(iso_mask_and), .mask_or(iso_mask_or), .uframe_tick(uframe_tick),
    .latency_uf(latency_uf), .irq(iso_irq)); // see RQ4
  uds_irq_group u_int (.core_clk(core_clk), .reset(reset), .done_map(done_q[1]),
    .mask_and(int_mask_and), .mask_or(int_mask_or), .uframe_tick(uframe_tick),
    .latency_uf(latency_uf), .irq(int_irq));
  uds_irq_group u_async (.core_clk(core_clk), .reset(reset), .done_map(done_q[2]),
    .mask_and(async_mask_and), .mask_or(async_mask_or), .uframe_tick(uframe_tick),
    .latency_uf(latency_uf), .irq(async_irq));

  property p_start_needs_valid;
    @(posedge core_clk) disable iff (reset)
    xact_start |-> w0_q[uds_pkg::W0_VALID] && !done_q[list_q][idx_q];
  endproperty
  a_start_needs_valid: assert property (p_start_needs_valid) else $error("start on invalid entry"); // see RQ9
  property p_forward_only;
    @(posedge core_clk) disable iff (reset)
    (state_q == uds_pkg::UDS_NEXT && !at_end && sched_en) |=> (idx_q > $past(idx_q));
  endproperty
  a_forward_only: assert property (p_forward_only) else $error("walk went backward"); // see RQ11
  property p_iso_first;
    @(posedge core_clk) disable iff (reset)
    (state_q == uds_pkg::UDS_IDLE && sched_en) |=> (list_q == 2'h0);
  endproperty
  a_iso_first: assert property (p_iso_first) else $error("iso list not first"); // see RQ2
  property p_skip_no_exec;
    @(posedge core_clk) disable iff (reset)
    (state_q == uds_pkg::UDS_RD4 && skip_v[idx_q]) |=> state_q == uds_pkg::UDS_NEXT;
  endproperty
  a_skip_no_exec: assert property (p_skip_no_exec) else $error("skipped entry executed"); // see RQ15
  property p_wb_clears_active;
    @(posedge core_clk) disable iff (reset)
    mem_wr |-> ((mem_word == uds_pkg::W3) ? !mem_wdata[uds_pkg::W3_ACTIVE] : !mem_wdata[uds_pkg::W0_VALID]);
  endproperty
  a_wb_clears_active: assert property (p_wb_clears_active) else $error("active not cleared"); // see RQ20
  property p_wb_marks_done;
    @(posedge core_clk) disable iff (reset)
    state_q == uds_pkg::UDS_WB |=> done_q[$past(list_q)][$past(idx_q)];
  endproperty
  a_wb_marks_done: assert property (p_wb_marks_done) else $error("done not set"); // see RQ7
  property p_sof_period;
    @(posedge core_clk) disable iff (reset)
    sof_irq |=> !sof_irq;
  endproperty
  a_sof_period: assert property (p_sof_period) else $error("sof not a pulse"); // see RQ4
  property p_retry_bound;
    @(posedge core_clk) disable iff (reset)
    (state_q == uds_pkg::UDS_WAIT && xact_pid_err && !xact_done && retry_q == uds_pkg::RETRY_MAX) |=>
      state_q == uds_pkg::UDS_WB;
  endproperty
  a_retry_bound: assert property (p_retry_bound) else $error("too many retries"); // see RQ21
  c_start: cover property (@(posedge core_clk) xact_start);
  c_async: cover property (@(posedge core_clk) list_q == 2'h2 && xact_start);
  c_babble: cover property (@(posedge core_clk) mem_wr && babble_q);
  c_retry: cover property (@(posedge core_clk) retry_go_q);
endmodule // uds_scheduler
`default_nettype wire
